/* verilog/cmc_modulator_ctrl.sv */
// Carrier modulator control, period registers and modulator timer behind an AXI4-Lite slave.
// What this block does
// (R1) Set end-of-cycle flag at counter reload.
// (R2) Request interrupt only when enable bit set.
// (R3) Space match ends cycle and reloads both.
// (R4) Space buffer copied every cycle end.
// (R5) Flag cleared by status read then low-byte period access.
// (R6) End-of-cycle flag is zero after reset.
// (R7) Software clears flag inside its service routine.
// (R8) Mark buffer is single buffered.
// (R9) Prescaler halves modulator clock rate.
// (R10) Mask bit masks external and keyscan requests.
// (R11) Extended space bit enables, resets clear.
// (R12) Baseband disables carrier, output high during mark.
// (R13) Mode bit selects frequency-shift or time mode.
// (R14) Enable initializes and starts continuous operation.
// (R15) Disable finishes cycle, then output low.
// (R16) Software programs registers before enabling.
// (R17) Low bytes of mark and space buffers.
// (R18) First register holds both upper nibbles.
// (R19) Mark nibble high, space nibble low.
// (R20) Extended space turns periods into pure space.
// (R21) Twelve-bit down counter, complement compared to space.
module cmc_modulator_ctrl (
    input  wire logic        aclk,              // System clock, the oscillator rate.
    input  wire logic        aresetn,           // Synchronous reset, active low.
    input  wire logic [3:0]  s_axi_awaddr,      // Write address.
    input  wire logic [2:0]  s_axi_awprot,      // Write protection, unused.
    input  wire logic        s_axi_awvalid,     // Write address valid.
    output logic             s_axi_awready,     // Write address ready.
    input  wire logic [31:0] s_axi_wdata,       // Write data.
    input  wire logic [3:0]  s_axi_wstrb,       // Write byte enables.
    input  wire logic        s_axi_wvalid,      // Write data valid.
    output logic             s_axi_wready,      // Write data ready.
    output logic [1:0]       s_axi_bresp,       // Write response.
    output logic             s_axi_bvalid,      // Write response valid.
    input  wire logic        s_axi_bready,      // Write response ready.
    input  wire logic [3:0]  s_axi_araddr,      // Read address.
    input  wire logic [2:0]  s_axi_arprot,      // Read protection, unused.
    input  wire logic        s_axi_arvalid,     // Read address valid.
    output logic             s_axi_arready,     // Read address ready.
    output logic [31:0]      s_axi_rdata,       // Read data.
    output logic [1:0]       s_axi_rresp,       // Read response.
    output logic             s_axi_rvalid,      // Read data valid.
    input  wire logic        s_axi_rready,      // Read data ready.
    input  wire logic        carrier_in,        // Carrier level from the carrier generator.
    input  wire logic        carrier_period,    // One-cycle pulse per carrier period.
    input  wire logic        ext_request_pin,   // External request pin, asynchronous.
    input  wire logic        keyscan_pin,       // Keyscan request, asynchronous.
    output logic             modulator_out,     // Modulated output to the emitter.
    output logic             carrier_enable,    // Runs the carrier generator.
    output logic             carrier_restart,   // Pulse that initializes the carrier generator.
    output logic             carrier_secondary, // Selects the secondary carrier pair.
    output logic             irq,               // Interrupt request to the CPU.
    output logic             ext_request_irq,   // Unmasked external request.
    output logic             keyscan_irq        // Unmasked keyscan request.
);
    import cmc_pkg::*;

    // Control bits and period buffers.
    logic [7:0]              ctrl;              // Control bits; bit 7 unused here.
    logic                    eoc;               // End-of-cycle flag.
    logic                    eoc_armed;         // Status read seen while flag set.
    logic [CMC_PERIOD_W-1:0] mark_period_buffer;
    logic [CMC_PERIOD_W-1:0] space_period_buffer;
    logic [CMC_PERIOD_W-1:0] active_space_register;
    logic [CMC_PERIOD_W-1:0] count;             // Modulator down counter.
    cmc_phase_e              phase;             // Modulator phase.
    logic                    long_space_active; // Current period is extended space.
    logic                    enable_q;          // Enable bit one cycle earlier.
    logic [4:0]              div_cnt;           // Time-mode tick divider.
    logic                    fsk_half;          // Halves carrier pulses under prescaler.
    logic                    tick;              // Modulator clock enable.
    logic                    reload;            // End of modulation cycle.
    logic                    start;             // Rising edge of the enable bit.
    logic [CMC_PERIOD_W-1:0] count_dec;         // Counter minus one.
    logic [1:0]              ext_sync;          // Synchroniser for the request pin.
    logic [1:0]              key_sync;          // Synchroniser for the keyscan pin.

    // Bus handshake state.
    logic                    aw_held;           // Write address taken.
    logic                    w_held;            // Write data taken.
    logic [3:0]              aw_addr;           // Stored write address.
    logic [7:0]              w_byte;            // Stored write data, low byte.
    logic                    w_lane0;           // Low byte lane enabled.
    logic                    wr_do;             // Write performed this cycle.
    logic                    rd_do;             // Read performed this cycle.

    // Decodes whether an address names one of the four registers.
    function automatic logic cmc_mapped(input logic [3:0] a);
        cmc_mapped = (a == CMC_ADDR_CTRL_STATUS) || (a == CMC_ADDR_UPPER) ||
                     (a == CMC_ADDR_MARK_LOW) || (a == CMC_ADDR_SPACE_LOW);
    endfunction

    // Decodes an access to either low-byte period register.
    function automatic logic cmc_low_reg(input logic [3:0] a);
        cmc_low_reg = (a == CMC_ADDR_MARK_LOW) || (a == CMC_ADDR_SPACE_LOW);
    endfunction

    // Write channels are accepted independently until both are held.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_do         = aw_held && w_held && !s_axi_bvalid;
    assign rd_do         = s_axi_arvalid && s_axi_arready;

    // Captures write address and data and issues the write response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 4'h0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= CMC_RESP_OKAY;
        end else begin
            // Address channel.
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            // Data channel.
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            // Both held: the write happens and the response is raised.
            if (wr_do) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= cmc_mapped(aw_addr) ? CMC_RESP_OKAY : CMC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Returns read data one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= CMC_RESP_OKAY;
        end else if (rd_do) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cmc_mapped(s_axi_araddr) ? CMC_RESP_OKAY : CMC_RESP_SLVERR;
            unique case (s_axi_araddr)
                // Status: flag and control bits.
                CMC_ADDR_CTRL_STATUS: s_axi_rdata <= {24'h000000, eoc, ctrl[6:0]};
                // Mark nibble high, space nibble low.
                CMC_ADDR_UPPER:       s_axi_rdata <= {24'h000000, mark_period_buffer[11:8],
                                                      space_period_buffer[11:8]};  // [R18] [R19]
                CMC_ADDR_MARK_LOW:    s_axi_rdata <= {24'h000000, mark_period_buffer[7:0]};   // [R17]
                CMC_ADDR_SPACE_LOW:   s_axi_rdata <= {24'h000000, space_period_buffer[7:0]};  // [R17]
                default:              s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Software-written control bits; all clear on reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CMC_CTRL_RESET;                                 // [R10] [R11] [R12] [R13]
        end else if (wr_do && w_lane0 && aw_addr == CMC_ADDR_CTRL_STATUS) begin
            ctrl <= {1'b0, w_byte[6:0]};
        end
    end

    // Period buffers; the mark buffer has no second stage.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mark_period_buffer  <= CMC_PERIOD_RESET;
            space_period_buffer <= CMC_PERIOD_RESET;
        end else if (wr_do && w_lane0) begin
            unique case (aw_addr)
                // Upper nibbles shared in one register.
                CMC_ADDR_UPPER: begin
                    mark_period_buffer[11:8]  <= w_byte[7:4];       // [R18] [R19]
                    space_period_buffer[11:8] <= w_byte[3:0];       // [R18] [R19]
                end
                CMC_ADDR_MARK_LOW:  mark_period_buffer[7:0]  <= w_byte;   // [R8] [R17]
                CMC_ADDR_SPACE_LOW: space_period_buffer[7:0] <= w_byte;   // [R17]
                default: ;
            endcase
        end
    end

    // End-of-cycle flag: a status read arms the clear, a low-byte access fires it; a set wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc       <= 1'b0;                                      // [R6]
            eoc_armed <= 1'b0;
        end else begin
            if (reload) begin
                eoc <= 1'b1;                                        // [R1]
            end else if (eoc_armed && ((wr_do && cmc_low_reg(aw_addr)) ||
                                       (rd_do && cmc_low_reg(s_axi_araddr)))) begin
                eoc <= 1'b0;                                        // [R5]
            end
            // Arming tracks a status read made while the flag is set.
            if (rd_do && s_axi_araddr == CMC_ADDR_CTRL_STATUS) begin
                eoc_armed <= eoc;                                   // [R5]
            end else if ((wr_do && cmc_low_reg(aw_addr)) || (rd_do && cmc_low_reg(s_axi_araddr))) begin
                eoc_armed <= 1'b0;
            end
        end
    end

    // Interrupt is the flag gated by the enable bit.
    assign irq = eoc && ctrl[CMC_BIT_IRQ_EN];                       // [R2]

    // Two-stage synchronisers for the external request pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync <= 2'b00;
            key_sync <= 2'b00;
        end else begin
            ext_sync <= {ext_sync[0], ext_request_pin};
            key_sync <= {key_sync[0], keyscan_pin};
        end
    end

    // External requests pass only while the mask bit is clear.
    assign ext_request_irq = ext_sync[1] && !ctrl[CMC_BIT_EXT_MASK];   // [R10]
    assign keyscan_irq     = key_sync[1] && !ctrl[CMC_BIT_EXT_MASK];   // [R10]

    // Modulator clock enable: oscillator divided in time mode, carrier periods in shift mode.
    always_ff @(posedge aclk) begin
        if (!aresetn || phase == CMC_IDLE) begin
            div_cnt  <= 5'd0;
            fsk_half <= 1'b0;
        end else if (ctrl[CMC_BIT_MODE]) begin
            if (carrier_period) begin
                fsk_half <= ctrl[CMC_BIT_HALF_RATE] ? !fsk_half : 1'b0;   // [R9]
            end
        end else if (tick) begin
            div_cnt <= 5'd0;
        end else begin
            div_cnt <= div_cnt + 5'd1;
        end
    end

    // Tick in time mode when the divider reaches its end, doubled under the prescaler; in shift mode on carrier period pulses.
    always_comb begin
        if (phase == CMC_IDLE) begin
            tick = 1'b0;
        end else if (ctrl[CMC_BIT_MODE]) begin
            tick = carrier_period && (!ctrl[CMC_BIT_HALF_RATE] || fsk_half);   // [R13] [R9]
        end else if (ctrl[CMC_BIT_HALF_RATE]) begin
            tick = div_cnt == 5'(CMC_OSC_PER_TICK * CMC_PRESCALE - 1);        // [R9]
        end else begin
            tick = div_cnt == 5'(CMC_OSC_PER_TICK - 1);
        end
    end

    assign start     = ctrl[CMC_BIT_ENABLE] && !enable_q && phase == CMC_IDLE;
    assign count_dec = count - 12'h001;

    // Cycle ends on the underflow tick with zero space, or when the complement matches the space.
    always_comb begin
        reload = 1'b0;
        if (tick && phase == CMC_MARK && count == 12'h000) begin
            reload = active_space_register == 12'h000;                        // [R3] [R21]
        end else if (tick && phase == CMC_SPACE) begin
            reload = ~count_dec == active_space_register;                     // [R3] [R21]
        end
    end

    // Modulator timer: mark countdown, underflow, space comparison and reload.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase                 <= CMC_IDLE;
            count                 <= CMC_PERIOD_RESET;
            active_space_register <= CMC_PERIOD_RESET;
            long_space_active     <= 1'b0;
            enable_q              <= 1'b0;
        end else begin
            enable_q <= ctrl[CMC_BIT_ENABLE];
            if (start) begin
                // Enable rising: initialize and run.
                phase                 <= CMC_MARK;                            // [R14]
                count                 <= mark_period_buffer;
                active_space_register <= space_period_buffer;
                long_space_active     <= ctrl[CMC_BIT_LONG_SPACE];
            end else if (reload) begin
                // End of cycle: load both buffers in either case; stop if disabled.
                phase                 <= ctrl[CMC_BIT_ENABLE] ? CMC_MARK : CMC_IDLE;   // [R15]
                count                 <= mark_period_buffer;                  // [R3] [R8]
                active_space_register <= space_period_buffer;                 // [R4]
                long_space_active     <= ctrl[CMC_BIT_LONG_SPACE];            // [R20] [R11]
            end else if (tick && phase == CMC_MARK && count == 12'h000) begin
                // Underflow closes the gate and the counter wraps.
                phase <= CMC_SPACE;                                           // [R21]
                count <= CMC_COUNT_MAX;
            end else if (tick) begin
                count <= count_dec;
            end
        end
    end

    // Frequency-shift mode swaps the carrier pair at each mark expiry.
    always_ff @(posedge aclk) begin
        if (!aresetn || start) begin
            carrier_secondary <= 1'b0;
        end else if (ctrl[CMC_BIT_MODE] && tick && phase == CMC_MARK && count == 12'h000) begin
            carrier_secondary <= !carrier_secondary;                          // [R13]
        end
    end

    // Carrier generator runs only while active and not in baseband.
    assign carrier_enable  = phase != CMC_IDLE && !ctrl[CMC_BIT_BASEBAND];   // [R12] [R14]
    assign carrier_restart = start;                                          // [R14]

    // Output register: gate open in mark unless extended space; baseband forces the carrier high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modulator_out <= 1'b0;
        end else if (phase == CMC_MARK && !long_space_active) begin
            modulator_out <= ctrl[CMC_BIT_BASEBAND] ? 1'b1 : carrier_in;      // [R12] [R20]
        end else begin
            modulator_out <= 1'b0;                                            // [R15]
        end
    end

    // Checks on the flag, interrupt, reload and output.
    eoc_set_a: assert property (@(posedge aclk) disable iff (!aresetn)     // [R1]
        reload |=> eoc)
        else $error("flag not set after cycle end");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [R2]
        $rose(eoc) |-> irq == ctrl[CMC_BIT_IRQ_EN])
        else $error("interrupt does not follow enable");
    mark_reload_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        reload && !start |=> count == $past(mark_period_buffer))
        else $error("counter not loaded from mark buffer");
    space_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R4]
        reload |=> active_space_register == $past(space_period_buffer))
        else $error("space buffer not copied");
    eoc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)   // [R5]
        $fell(eoc) |-> $past(eoc_armed))
        else $error("flag cleared without status read");
    eoc_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)   // [R6]
        $past(aresetn) == 1'b0 |-> !eoc)
        else $error("flag not clear after reset");
    stop_low_a: assert property (@(posedge aclk) disable iff (!aresetn)    // [R15]
        phase == CMC_IDLE ##1 phase == CMC_IDLE |-> !modulator_out)
        else $error("output not low while stopped");
    baseband_select_high_a: assert property (@(posedge aclk) disable iff (!aresetn)   // [R12]
        phase == CMC_MARK && !long_space_active && ctrl[CMC_BIT_BASEBAND] |=> modulator_out)
        else $error("baseband output not high in mark");
    long_space_a: assert property (@(posedge aclk) disable iff (!aresetn)  // [R20]
        long_space_active |=> !modulator_out)
        else $error("output active during extended space");
    mask_a: assert property (@(posedge aclk) disable iff (!aresetn)        // [R10]
        ctrl[CMC_BIT_EXT_MASK] |-> !ext_request_irq && !keyscan_irq)
        else $error("masked request passed");
endmodule

/* include/cmc_pkg.sv */
// Package with register map, field positions and timing constants of the carrier modulator control block.
package cmc_pkg;
    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [3:0] CMC_ADDR_CTRL_STATUS = 4'h0;    // Control and status register.
    localparam logic [3:0] CMC_ADDR_UPPER       = 4'h4;    // Upper nibbles of both periods.
    localparam logic [3:0] CMC_ADDR_MARK_LOW    = 4'h8;    // Low byte of the mark period.
    localparam logic [3:0] CMC_ADDR_SPACE_LOW   = 4'hc;    // Low byte of the space period.
    // Field positions in the control and status register.
    localparam int CMC_BIT_EOC        = 7;                 // End-of-cycle flag.
    localparam int CMC_BIT_HALF_RATE  = 6;                 // Half-rate prescaler.
    localparam int CMC_BIT_EXT_MASK   = 5;                 // External request mask.
    localparam int CMC_BIT_LONG_SPACE = 4;                 // Extended space enable.
    localparam int CMC_BIT_BASEBAND   = 3;                 // Baseband select.
    localparam int CMC_BIT_MODE       = 2;                 // Frequency-shift mode select.
    localparam int CMC_BIT_IRQ_EN     = 1;                 // Interrupt request enable.
    localparam int CMC_BIT_ENABLE     = 0;                 // Modulator and generator enable.
    // Reset values.
    localparam logic [7:0]  CMC_CTRL_RESET   = 8'h00;      // All control bits clear.
    localparam logic [11:0] CMC_PERIOD_RESET = 12'h000;    // Period buffers clear.
    // Period widths.
    localparam int CMC_PERIOD_W = 12;                      // Mark and space buffer width.
    localparam logic [11:0] CMC_COUNT_MAX = 12'hfff;       // Counter value after underflow.
    // Timing: time mode counts one tick per eight oscillator cycles, per sixteen under the prescaler.
    localparam int CMC_OSC_PER_TICK = 8;                   // Oscillator cycles per modulator tick.
    localparam int CMC_PRESCALE     = 2;                   // Factor of the half-rate prescaler.
    // AXI responses.
    localparam logic [1:0] CMC_RESP_OKAY   = 2'b00;        // Access done.
    localparam logic [1:0] CMC_RESP_SLVERR = 2'b10;        // Unmapped address.
    // Modulator phase.
    typedef enum logic [1:0] {
        CMC_IDLE  = 2'b00,                                 // Stopped, output low.
        CMC_MARK  = 2'b01,                                 // Counter decrementing, gate open unless extended space.
        CMC_SPACE = 2'b10                                  // Gate closed, comparing with space.
    } cmc_phase_e;
endpackage

/* testbench/cmc_emitter_model.sv */
// Emitter model on the modulated output that counts the bursts it sends.
module cmc_emitter_model (
    input  wire logic aclk,          // System clock.
    input  wire logic modulator_out, // Drive from the block, high while emitting.
    output int        burst_cnt      // Number of bursts seen so far.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0; // Level of the drive one cycle earlier.
    int   cnt  = 0;    // Running burst count.
    // Each rising edge of the drive starts one burst.
    always @(posedge aclk) begin
        last <= modulator_out;
        if (modulator_out === 1'b1 && last !== 1'b1) cnt <= cnt + 1;
    end
    assign burst_cnt = cnt;
endmodule

/* testbench/cmc_modulator_ctrl_tb.sv */
// Self-checking bench of the carrier modulator control block.
module cmc_modulator_ctrl_tb;
    import cmc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0, ext_request_pin = 1'b0, keyscan_pin = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        modulator_out, carrier_enable, irq, ext_request_irq, keyscan_irq, carrier_restart, carrier_secondary;
    logic        carrier_in = 1'b0, carrier_period = 1'b0, sec_q = 1'b0;
    int          error_cnt = 0, n_tests = 0, cyc = 0, bursts, flips = 0, starts = 0;
    // The 25 MHz system clock.
    always #20 aclk = ~aclk;
    // Two-cycle carrier with one period pulse each; counts restarts and carrier pair swaps.
    always @(posedge aclk) begin
        carrier_in <= ~carrier_in;
        carrier_period <= ~carrier_in;
        sec_q <= carrier_secondary;
        if (aresetn && carrier_secondary !== sec_q) flips <= flips + 1;
        if (carrier_restart === 1'b1) starts <= starts + 1;
    end
    cmc_modulator_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .carrier_in, .carrier_period, .ext_request_pin, .keyscan_pin,
        .modulator_out, .carrier_enable, .carrier_restart, .carrier_secondary, .irq, .ext_request_irq,
        .keyscan_irq);
    cmc_emitter_model emitter (.aclk, .modulator_out, .burst_cnt(bursts));
    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write: address and data offered together, each released when taken.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Bus read: data and response are taken at the edge that shows rvalid.
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Reset values, nibble packing and an unmapped address.
    task automatic t_regs;
        rd(CMC_ADDR_CTRL_STATUS);
        chk(d, 32'h0);
        wr(CMC_ADDR_UPPER, 8'ha5);
        rd(CMC_ADDR_UPPER);
        chk(d, 32'ha5);
        wr(CMC_ADDR_UPPER, 8'h00);
        rd(4'h2);
        chk({30'h0, r}, {30'h0, CMC_RESP_SLVERR});
        wr(4'h2, 8'hff);
        chk({30'h0, r}, {30'h0, CMC_RESP_SLVERR});
    endtask
    // Running cycle with interrupt; clearing needs the status read first.
    task automatic t_eoc;
        wr(CMC_ADDR_MARK_LOW, 8'h02);
        wr(CMC_ADDR_SPACE_LOW, 8'h01);
        wr(CMC_ADDR_CTRL_STATUS, 8'h03);
        for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge aclk);
        chk(irq, 1'b1);
        wr(CMC_ADDR_SPACE_LOW, 8'h01);
        chk(irq, 1'b1);
        rd(CMC_ADDR_CTRL_STATUS);
        chk(d, 32'h83);
        wr(CMC_ADDR_MARK_LOW, 8'h02);
        chk(irq, 1'b0);
        chk(bursts > 0, 1'b1);
    endtask
    // Flag still sets with the interrupt enable clear, but no request.
    task automatic t_noirq;
        wr(CMC_ADDR_CTRL_STATUS, 8'h01);
        repeat (80) @(posedge aclk);
        chk(irq, 1'b0);
        rd(CMC_ADDR_CTRL_STATUS);
        chk(d, 32'h81);
    endtask
    // Baseband stops the carrier; disabling ends the cycle and idles the output.
    task automatic t_stop;
        int b;
        wr(CMC_ADDR_CTRL_STATUS, 8'h09);
        chk(carrier_enable, 1'b0);
        wr(CMC_ADDR_CTRL_STATUS, 8'h00);
        repeat (80) @(posedge aclk);
        b = bursts;
        repeat (80) @(posedge aclk);
        chk({modulator_out, carrier_enable}, 2'b00);
        chk(bursts, b);
    endtask
    // External and keyscan requests pass until masked.
    task automatic t_mask;
        ext_request_pin <= 1'b1;
        keyscan_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({ext_request_irq, keyscan_irq}, 2'b11);
        wr(CMC_ADDR_CTRL_STATUS, 8'h20);
        chk({ext_request_irq, keyscan_irq}, 2'b00);
    endtask
    // Shift mode swaps the carrier pair; extended space silences the output.
    task automatic t_fsk;
        int b;
        chk(flips, 0);
        wr(CMC_ADDR_MARK_LOW, 8'h02);
        rd(CMC_ADDR_CTRL_STATUS);
        chk(d, 32'h20);
        b = bursts;
        wr(CMC_ADDR_CTRL_STATUS, 8'h25);
        repeat (80) @(posedge aclk);
        chk(flips > 0, 1'b1);
        chk(bursts > b, 1'b1);
        chk(starts, 2);
        wr(CMC_ADDR_CTRL_STATUS, 8'h35);
        repeat (20) @(posedge aclk);
        b = bursts;
        repeat (40) @(posedge aclk);
        chk(bursts, b);
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_eoc();
        t_noirq();
        t_stop();
        t_mask();
        t_fsk();
        complete_run();
    end
endmodule
